// ### src/dbgma_pkg.sv
// Package of constants shared by the debug block memory access logic.
package dbgma_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    // Command byte layout: group in the high nibble, size in bits 3:2, variant in bits 1:0.
    localparam logic [3:0] GRP_READ = 4'h3;
    localparam logic [3:0] GRP_WRITE = 4'h1;
    localparam logic [1:0] VAR_SINGLE = 2'h0;
    localparam logic [1:0] VAR_SINGLE_WS = 2'h1;
    localparam logic [1:0] VAR_BLOCK = 2'h2;
    localparam logic [1:0] VAR_BLOCK_WS = 2'h3;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_DUMP_B_WS = 8'h33;
    localparam logic [7:0] CMD_DUMP_W_WS = 8'h37;
    localparam logic [7:0] CMD_DUMP_L_WS = 8'h3B;
    localparam logic [7:0] CMD_FILL_B_WS = 8'h13;
    localparam logic [7:0] CMD_FILL_W_WS = 8'h17;
    // Operand size codes.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // Number of address bytes that follow a single read or write command.
    localparam logic [2:0] ADDR_BYTES = 3'h3;
    // Delay slot length in system clock cycles.
    localparam logic [7:0] DELAY_SLOT_CYCLES = 8'h10;
    // Field positions inside the low status byte.
    localparam int STAT_ACK_EN_BIT = 7;
    localparam int STAT_ILLEGAL_BIT = 6;
    localparam int STAT_MEM_ERR_BIT = 5;
    localparam logic [ADDR_W-1:0] PTR_RESET = 24'h000000;
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : dbgma_pkg

// ### src/dbgma_ptr_if.sv
// Interface between the command engine and the debug address pointer.
interface dbgma_ptr_if;
    logic load;
    logic [dbgma_pkg::ADDR_W-1:0] loadAddr;
    logic advance;
    logic [1:0] size;
    logic [dbgma_pkg::ADDR_W-1:0] addr;
    modport engine (output load, output loadAddr, output advance, output size, input addr);
    modport pointer (input load, input loadAddr, input advance, input size, output addr);
endinterface : dbgma_ptr_if

// ### src/dbgma_ptr.sv
// Debug address pointer with load and size-dependent advance.
module dbgma_ptr (
    input wire logic sys_clk,
    input wire logic reset_n,
    dbgma_ptr_if.pointer ptr
);
    logic [dbgma_pkg::ADDR_W-1:0] addr_reg;
    wire logic [dbgma_pkg::ADDR_W-1:0] step;
    wire logic [dbgma_pkg::ADDR_W-1:0] addr_next;

    // R15 one increment rule
    assign step = dbgma_pkg::ADDR_W'(1) << ptr.size;
    // R4 add operand size
    assign addr_next = ptr.load ? ptr.loadAddr : (ptr.advance ? addr_reg + step : addr_reg);
    assign ptr.addr = addr_reg;

    // R5 store updated address
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            addr_reg <= dbgma_pkg::PTR_RESET;
        end else begin
            addr_reg <= addr_next;
        end
    end
endmodule : dbgma_ptr

// ### src/dbgma_core.sv
// Command engine for debug block reads and writes of target memory.
// Operation
// R1: Block read with status: codes 33,37,3B; delay, status, data MSB first.
// R2: Block read runs without halting and reads at pointer, then advances it.
// R3: Host issues a single memory read first to set the block start.
// R4: After the single read the pointer gains the operand size.
// R5: Each block read uses pointer, adds its size, stores the result.
// R6: Status variant sends the status byte captured after the read.
// R7: With acknowledge enabled, an ack pulse precedes block read data; the code pulses ack only for variants without status, not for 33,37,3B.
// R8: Block read only after sync, no-op, read or block read; else illegal; the code allows it after a no-op only if it was allowed before the no-op.
// R9: No-operation leaves the address pointer untouched.
// R10: Size field decoded anew for each block read command.
// R11: Block write stores host data at pointer, then advances it.
// R12: Block write with status: codes 13,17; data MSB first, delay, status.
// R13: Host holds the pin low 128 slow clocks to request sync.
// R14: Single memory read loads the pointer from the host address.
// R15: Unaligned operands advance by one consistent size-based rule.
module dbgma_core (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic syncDone,
    input wire logic ackEnable,
    input wire logic clearIllegal,
    output logic txValid,
    output logic [7:0] txByte,
    input wire logic txReady,
    output logic ackPulse,
    output logic illegalResp,
    output logic illegal_command_flag,
    output logic memReq,
    output logic memWe,
    output logic [1:0] memSize,
    output logic [dbgma_pkg::ADDR_W-1:0] memAddr,
    output logic [dbgma_pkg::DATA_W-1:0] memWdata,
    input wire logic [dbgma_pkg::DATA_W-1:0] memRdata,
    input wire logic memErr,
    input wire logic memDone
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_WDATA, ST_MEM, ST_DELAY, ST_ACK, ST_SEND
    } dbgma_state_t;

    dbgma_state_t state_reg;
    dbgma_state_t state_next;
    logic [7:0] cmd_reg;
    logic [dbgma_pkg::ADDR_W-1:0] addrShift_reg;
    logic [dbgma_pkg::DATA_W-1:0] wdata_reg;
    logic [39:0] outShift_reg;
    logic [2:0] cnt_reg;
    logic [7:0] delay_reg;
    logic illegal_reg;
    logic dumpOk_reg;
    logic memBusy_reg;
    logic [dbgma_pkg::DATA_W-1:0] rdata_reg;
    logic [7:0] statusSnap_reg;
    logic memReq_reg;
    logic [dbgma_pkg::ADDR_W-1:0] memAddr_reg;

    dbgma_ptr_if ptrBus ();

    dbgma_ptr u_ptr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ptr(ptrBus.pointer)
    );

    // The byte shifters below are written for a 24-bit address and a 32-bit data word.
    if ((dbgma_pkg::ADDR_W != 24) || (dbgma_pkg::DATA_W != 32)) begin : g_widthCheck
        $error("dbgma_core serves only a 24-bit address and a 32-bit data word.");
    end

    // Decode of the arriving command byte.
    wire logic cmdArrive = rxValid && (state_reg == ST_IDLE);
    wire logic [3:0] inGrp = rxByte[7:4];
    wire logic [1:0] inSz = rxByte[3:2];
    wire logic [1:0] inVar = rxByte[1:0];
    wire logic inSzOk = (inSz != 2'h3);
    wire logic inRead = (inGrp == dbgma_pkg::GRP_READ) && inSzOk;
    wire logic inWrite = (inGrp == dbgma_pkg::GRP_WRITE) && inSzOk;
    wire logic inBlock = inVar[1];
    wire logic inNop = (rxByte == dbgma_pkg::CMD_NOP);
    // R8 dump sequencing check
    wire logic dumpBad = inRead && inBlock && !dumpOk_reg;
    wire logic inUnknown = !inRead && !inWrite && !inNop;
    wire logic cmdIllegal = cmdArrive && (dumpBad || inUnknown);

    // Fields of the command in progress.
    wire logic [1:0] curSz = cmd_reg[3:2];
    wire logic curRead = (cmd_reg[7:4] == dbgma_pkg::GRP_READ);
    wire logic curWs = cmd_reg[0];
    wire logic [2:0] nBytes = 3'h1 << curSz;
    wire logic lastRx = (cnt_reg == 3'h1);
    wire logic [dbgma_pkg::ADDR_W-1:0] fullAddr = {addrShift_reg[15:0], rxByte};
    wire logic [dbgma_pkg::DATA_W-1:0] fullWdata = {wdata_reg[23:0], rxByte};

    // Status byte as it stands now; it is sampled when the access completes.
    wire logic [7:0] statusNow = {ackEnable, illegal_reg, memErr, 5'h00};
    // Read data moved to the top so that the most significant byte goes first.
    wire logic [4:0] alignShift = {2'h0, 3'h4 - nBytes} << 3;
    wire logic [dbgma_pkg::DATA_W-1:0] rdAligned = rdata_reg << alignShift;
    wire logic [39:0] sendRead = curWs ? {statusSnap_reg, rdAligned} : {rdAligned, 8'h00};
    wire logic [39:0] sendWrite = {statusSnap_reg, 32'h00000000};
    wire logic [2:0] sendCount = curRead ? (nBytes + {2'h0, curWs}) : 3'h1;
    wire logic delayDone = (delay_reg == 8'h00);
    wire logic needAck = ackEnable && !curWs;
    wire logic accessDone = (state_reg == ST_MEM) && memBusy_reg && memDone;

    // R14 load pointer from host address
    assign ptrBus.load = (state_reg == ST_ADDR) && rxValid && lastRx;
    // Writes with an address also load the pointer so that block writes can follow.
    assign ptrBus.loadAddr = fullAddr;
    // R2 advance after each access
    assign ptrBus.advance = accessDone;
    // R10 size taken per command
    assign ptrBus.size = curSz;

    assign txValid = (state_reg == ST_SEND);
    assign txByte = outShift_reg[39:32];
    // R7 ack before data
    assign ackPulse = (state_reg == ST_ACK);
    assign illegalResp = cmdIllegal;
    assign illegal_command_flag = illegal_reg;
    assign memReq = memReq_reg;
    assign memAddr = memAddr_reg;
    assign memWe = !curRead;
    assign memSize = curSz;
    assign memWdata = wdata_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (cmdArrive && !cmdIllegal && !inNop) begin
                    if (inRead && inBlock) begin
                        state_next = ST_MEM;
                    end else if (inWrite && inBlock) begin
                        state_next = ST_WDATA;
                    end else begin
                        state_next = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (rxValid && lastRx) begin
                    state_next = curRead ? ST_MEM : ST_WDATA;
                end
            end
            ST_WDATA: begin
                if (rxValid && lastRx) begin
                    state_next = ST_MEM;
                end
            end
            ST_MEM: begin
                if (accessDone) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (delayDone) begin
                    if (curWs) begin
                        state_next = ST_SEND;
                    end else if (needAck) begin
                        state_next = ST_ACK;
                    end else begin
                        state_next = curRead ? ST_SEND : ST_IDLE;
                    end
                end
            end
            ST_ACK: begin
                state_next = curRead ? ST_SEND : ST_IDLE;
            end
            ST_SEND: begin
                if (txReady && lastRx) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Command capture and byte counting.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cmd_reg <= dbgma_pkg::CMD_NOP;
            cnt_reg <= 3'h0;
        end else begin
            if (cmdArrive && !cmdIllegal && !inNop) begin
                cmd_reg <= rxByte;
                cnt_reg <= inBlock ? (3'h1 << inSz) : dbgma_pkg::ADDR_BYTES;
            end else if ((state_reg == ST_ADDR) && rxValid) begin
                cnt_reg <= lastRx ? nBytes : cnt_reg - 3'h1;
            end else if ((state_reg == ST_WDATA) && rxValid) begin
                cnt_reg <= cnt_reg - 3'h1;
            end else if ((state_reg == ST_DELAY) && delayDone) begin
                cnt_reg <= sendCount;
            end else if ((state_reg == ST_SEND) && txReady) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end

    // Write data is cleared per command so short operands carry no bytes of an earlier one.
    // R12 data MSB first
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            addrShift_reg <= dbgma_pkg::PTR_RESET;
            wdata_reg <= 32'h00000000;
        end else if (cmdArrive) begin
            wdata_reg <= 32'h00000000;
        end else if ((state_reg == ST_ADDR) && rxValid) begin
            addrShift_reg <= fullAddr;
        end else if ((state_reg == ST_WDATA) && rxValid) begin
            wdata_reg <= fullWdata;
        end
    end

    // The busy flag keeps the request a single pulse however slowly the memory answers.
    // R11 write at pointer
    // R2 access at pointer
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            memReq_reg <= 1'b0;
            memBusy_reg <= 1'b0;
            memAddr_reg <= dbgma_pkg::PTR_RESET;
        end else begin
            memReq_reg <= (state_reg == ST_MEM) && !memBusy_reg;
            if ((state_reg == ST_MEM) && !memBusy_reg) begin
                memBusy_reg <= 1'b1;
                memAddr_reg <= ptrBus.addr;
            end else if (accessDone) begin
                memBusy_reg <= 1'b0;
            end
        end
    end

    // Read data is taken in the answer cycle, as the memory need not hold it through the slot.
    // R6 status after the read
    // R12 status ends a block write
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            statusSnap_reg <= dbgma_pkg::STATUS_RESET;
            rdata_reg <= 32'h00000000;
            delay_reg <= 8'h00;
        end else if (accessDone) begin
            statusSnap_reg <= statusNow;
            rdata_reg <= memRdata;
            delay_reg <= dbgma_pkg::DELAY_SLOT_CYCLES;
        end else if ((state_reg == ST_DELAY) && !delayDone) begin
            delay_reg <= delay_reg - 8'h01;
        end
    end

    // R1 status then data, MSB first
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            outShift_reg <= 40'h0000000000;
        end else if (accessDone) begin
            outShift_reg <= 40'h0000000000;
        end else if ((state_reg == ST_DELAY) && delayDone) begin
            outShift_reg <= curRead ? sendRead : sendWrite;
        end else if ((state_reg == ST_SEND) && txReady) begin
            outShift_reg <= {outShift_reg[31:0], 8'h00};
        end
    end

    // R8 flag set on illegal command
    // The set wins over a clear that lands in the same cycle, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            illegal_reg <= 1'b0;
        end else if (cmdIllegal) begin
            illegal_reg <= 1'b1;
        end else if (clearIllegal) begin
            illegal_reg <= 1'b0;
        end
    end

    // A refused or write command breaks the chain, so the host must read once more first.
    // R8 track what preceded a block read
    // R9 no-op keeps the chain and the pointer
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dumpOk_reg <= 1'b0;
        end else if (syncDone) begin
            dumpOk_reg <= 1'b1;
        end else if (cmdArrive) begin
            if (inNop) begin
                dumpOk_reg <= dumpOk_reg;
            end else begin
                dumpOk_reg <= inRead && !cmdIllegal;
            end
        end
    end
endmodule : dbgma_core

// ### bench/dbgma_core_asserts.sv
// Concurrent checks on the ports of the debug memory access engine.
module dbgma_core_asserts (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic ackEnable,
    input wire logic txValid,
    input wire logic [7:0] txByte,
    input wire logic txReady,
    input wire logic ackPulse,
    input wire logic illegalResp,
    input wire logic illegal_command_flag,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [1:0] memSize,
    input wire logic [dbgma_pkg::ADDR_W-1:0] memAddr,
    input wire logic memErr,
    input wire logic memDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [dbgma_pkg::ADDR_W-1:0] nextAddr_reg;
    logic errSeen_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // The expected pointer steps by the size alone, so misaligned accesses are held to it too.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            nextAddr_reg <= dbgma_pkg::PTR_RESET;
            errSeen_reg <= 1'h0;
        end else begin
            if (memReq) nextAddr_reg <= memAddr + (24'h1 << memSize);
            if (memDone) errSeen_reg <= memErr;
        end
    end
    sequence dumpCmd;
        rxValid && !illegalResp && rxByte[7:4] == dbgma_pkg::GRP_READ && rxByte[1];
    endsequence
    sequence dumpAccess;
        ##2 memReq && !memWe && memSize == $past(rxByte[3:2], 2) && memAddr == nextAddr_reg;
    endsequence
    sequence quietSlot;
        (!txValid && !ackPulse) [*8];
    endsequence
    a_dump_read_ptr: assert property (dumpCmd |-> dumpAccess)
        else $error("block read address or size wrong");
    a_illegal_flag_set: assert property (illegalResp |=> illegal_command_flag)
        else $error("illegal flag not set");
    a_illegal_no_access: assert property (illegalResp |=> !memReq [*3])
        else $error("refused command reached memory");
    a_status_bits: assert property ($rose(txValid) && !$past(ackPulse) |->
        txByte == {ackEnable, illegal_command_flag, errSeen_reg, 5'h00})
        else $error("status byte wrong");
    a_delay_quiet: assert property (memDone |=> quietSlot)
        else $error("answer inside delay slot");
    a_answer_slot: assert property (memDone |-> ##18 (txValid || ackPulse))
        else $error("answer not after delay slot");
    a_ack_then_data: assert property (ackPulse && !memWe |=> txValid)
        else $error("no data after acknowledge");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("response byte not held");
    a_req_pulse: assert property (memReq |=> !memReq)
        else $error("access request longer than one cycle");
endmodule : dbgma_core_asserts

bind dbgma_core dbgma_core_asserts u_chk (.sys_clk, .reset_n, .rxValid, .rxByte, .ackEnable,
    .txValid, .txByte, .txReady, .ackPulse, .illegalResp, .illegal_command_flag,
    .memReq, .memWe, .memSize, .memAddr, .memErr, .memDone);

// ### bench/dbgma_mem_model.sv
// Target memory model answering the engine's access requests.
module dbgma_mem_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [1:0] memSize,
    input wire logic [dbgma_pkg::ADDR_W-1:0] memAddr,
    input wire logic [dbgma_pkg::DATA_W-1:0] memWdata,
    input wire logic [3:0] latency,
    input wire logic [dbgma_pkg::ADDR_W-1:0] errAddr,
    output logic [dbgma_pkg::DATA_W-1:0] memRdata,
    output logic memErr,
    output logic memDone,
    output logic [dbgma_pkg::ADDR_W-1:0] lastWaddr,
    output logic [dbgma_pkg::DATA_W-1:0] lastWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt_reg;
    logic [dbgma_pkg::DATA_W-1:0] readVal;
    always_comb begin
        readVal = 32'h00000000;
        for (int i = 0; i < (1 << memSize); i++) begin
            readVal = {readVal[23:0], (memAddr[7:0] + 8'(i)) ^ 8'h5A};
        end
    end
    assign memDone = (waitCnt_reg == 4'h1);
    assign memErr = memDone && (memAddr == errAddr);
    // Outside the answer cycle the lines carry the inverse, so stale data cannot pass.
    assign memRdata = memDone ? readVal : ~readVal;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            waitCnt_reg <= 4'h0;
        end else if (memReq) begin
            waitCnt_reg <= latency;
        end else if (waitCnt_reg != 4'h0) begin
            waitCnt_reg <= waitCnt_reg - 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (memDone && memWe) begin
            lastWaddr <= memAddr;
            lastWdata <= memWdata;
        end
    end
endmodule : dbgma_mem_model

// ### bench/dbgma_core_bench.sv
// Self-checking bench for the debug block memory access engine.
module dbgma_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, rxValid, syncDone, ackEnable, clearIllegal, txReady, sawIll;
    logic txValid, ackPulse, illegalResp, illegal_command_flag, memReq, memWe, memErr, memDone;
    logic [7:0] rxByte, txByte;
    logic [1:0] memSize;
    logic [3:0] latency;
    logic [dbgma_pkg::ADDR_W-1:0] memAddr, errAddr, lastWaddr;
    logic [dbgma_pkg::DATA_W-1:0] memWdata, memRdata, lastWdata;
    int n_mismatch = 0;
    int checked = 0;
    dbgma_core DUT (.sys_clk, .reset_n, .rxValid, .rxByte, .syncDone, .ackEnable, .clearIllegal,
        .txValid, .txByte, .txReady, .ackPulse, .illegalResp, .illegal_command_flag, .memReq,
        .memWe, .memSize, .memAddr, .memWdata, .memRdata, .memErr, .memDone);
    dbgma_mem_model u_mem (.sys_clk, .reset_n, .memReq, .memWe, .memSize, .memAddr, .memWdata,
        .latency, .errAddr, .memRdata, .memErr, .memDone, .lastWaddr, .lastWdata);
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    function automatic logic [7:0] memByte(input logic [23:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction : memByte
    // A gap cycle after each byte keeps the strobe a true single-cycle pulse.
    task automatic send(input logic [7:0] b);
        rxValid = 1'h1;
        rxByte = b;
        #1 sawIll = illegalResp;
        @(negedge sys_clk);
        rxValid = 1'h0;
        @(negedge sys_clk);
    endtask : send
    task automatic sendAddr(input logic [23:0] a);
        send(a[23:16]);
        send(a[15:8]);
        send(a[7:0]);
    endtask : sendAddr
    task automatic expectByte(input logic [7:0] exp);
        int k;
        for (k = 0; k < 200 && txValid !== 1'h1; k++) @(negedge sys_clk);
        if (k == 200) begin
            n_mismatch++;
            give_verdict();
        end
        compare(txByte, exp);
        txReady = 1'h1;
        @(negedge sys_clk);
        txReady = 1'h0;
        @(negedge sys_clk);
    endtask : expectByte
    task automatic expectRead(input logic [7:0] st, input logic [23:0] a, input int n);
        expectByte(st);
        for (int i = 0; i < n; i++) expectByte(memByte(a + 24'(i)));
    endtask : expectRead
    task automatic clearFlag();
        clearIllegal = 1'h1;
        @(negedge sys_clk);
        clearIllegal = 1'h0;
        @(negedge sys_clk);
        compare(illegal_command_flag, 1'h0);
    endtask : clearFlag
    task automatic test_illegal_start();
        send(dbgma_pkg::CMD_DUMP_B_WS);
        compare(sawIll, 1'h1);
        compare(illegal_command_flag, 1'h1);
        send(8'hFF);
        compare(sawIll, 1'h1);
        clearFlag();
        $display("test illegal_start done");
    endtask : test_illegal_start
    task automatic test_sync_dump();
        syncDone = 1'h1;
        @(negedge sys_clk);
        syncDone = 1'h0;
        send(dbgma_pkg::CMD_DUMP_W_WS);
        expectRead(8'h80, 24'h000000, 2);
        $display("test sync_dump done");
    endtask : test_sync_dump
    task automatic test_dump_chain();
        ackEnable = 1'h0;
        latency = 4'h1;
        errAddr = 24'h000201;
        send(8'h31);
        sendAddr(24'h0001FF);
        expectRead(8'h00, 24'h0001FF, 1);
        send(dbgma_pkg::CMD_NOP);
        send(dbgma_pkg::CMD_DUMP_B_WS);
        expectRead(8'h00, 24'h000200, 1);
        latency = 4'h9;
        send(dbgma_pkg::CMD_DUMP_L_WS);
        expectRead(8'h20, 24'h000201, 4);
        send(dbgma_pkg::CMD_DUMP_W_WS);
        expectRead(8'h00, 24'h000205, 2);
        ackEnable = 1'h1;
        $display("test dump_chain done");
    endtask : test_dump_chain
    task automatic test_fill();
        send(8'h15);
        sendAddr(24'h000400);
        send(8'hAB);
        send(8'hCD);
        expectByte(8'h80);
        compare(lastWdata, 32'h0000ABCD);
        send(dbgma_pkg::CMD_FILL_B_WS);
        send(8'hEF);
        expectByte(8'h80);
        compare(lastWaddr, 24'h000402);
        compare(lastWdata, 32'h000000EF);
        send(dbgma_pkg::CMD_FILL_W_WS);
        send(8'hC1);
        send(8'hD2);
        expectByte(8'h80);
        compare({lastWaddr[15:0], lastWdata[15:0]}, 32'h0403C1D2);
        send(dbgma_pkg::CMD_DUMP_B_WS);
        compare(sawIll, 1'h1);
        clearFlag();
        $display("test fill done");
    endtask : test_fill
    task automatic test_ack_dump();
        int k;
        send(8'h31);
        sendAddr(24'h000010);
        expectRead(8'h80, 24'h000010, 1);
        send(8'h36);
        for (k = 0; k < 200 && ackPulse !== 1'h1; k++) @(negedge sys_clk);
        compare(k < 200, 1'h1);
        expectByte(memByte(24'h000011));
        expectByte(memByte(24'h000012));
        $display("test ack_dump done");
    endtask : test_ack_dump
    initial begin
        reset_n = 1'h0;
        rxValid = 1'h0;
        rxByte = 8'h00;
        syncDone = 1'h0;
        ackEnable = 1'h1;
        clearIllegal = 1'h0;
        txReady = 1'h0;
        latency = 4'h3;
        errAddr = 24'hFFFFFF;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'h1;
        test_illegal_start();
        test_sync_dump();
        test_dump_chain();
        test_fill();
        test_ack_dump();
        give_verdict();
    end
endmodule : dbgma_core_bench
